// ==== hw/lcao_core.sv ====
// Execution unit for AND, compare-branch, bit clear, BCD adjust, decrement
// Functional notes
// - Carry becomes carry AND addressed bit
// - Memory byte ANDed with immediate, written back
// - Memory byte ANDed with accumulator, written back
// - Indirect byte versus immediate, branch if unequal
// - Compare sets carry when second operand larger
// - Accumulator versus immediate, branch if unequal
// - Accumulator versus memory byte, branch if unequal
// - Bank register versus immediate, branch if unequal
// - Addressed bit forced to zero, flags kept
// - Low digit plus six if above nine/half-carry
// - High digit plus six if above nine/carry, carry set
// - Memory byte decremented, written back, flags kept
`timescale 1ns/1ns
`include "lcao_consts.svh"
module lcao_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [7:0] issue_opcode,
  input wire logic [7:0] issue_byte2,
  input wire logic [7:0] issue_byte3,
  input wire logic [15:0] issue_pc,
  input wire logic [7:0] acc_in,
  input wire logic carry_in,
  input wire logic half_carry_flag_in,
  output logic [2:0] bank_reg_sel,
  input wire logic [7:0] bank_reg_data,
  output logic mem_rd,
  output logic [7:0] mem_addr,
  output logic mem_bit,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic carry_we,
  output logic carry_out,
  output logic acc_we,
  output logic [7:0] acc_out,
  output logic done,
  output logic illegal,
  output logic branch_taken,
  output logic [15:0] next_pc
);
  lcao_pkg::lcao_regs_t r;
  lcao_pkg::lcao_regs_t next_r;
  lcao_pkg::lcao_dec_t dec;
  logic cycle_en;
  logic last;
  logic take;
  logic [7:0] first;
  logic [7:0] second;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_eq;

  function automatic lcao_pkg::lcao_dec_t lcao_decode(input logic [7:0] op);
    lcao_pkg::lcao_dec_t d;
    d = '0;
    d.len = `LCAO_LEN_1;
    d.ncyc = `LCAO_CYC_1;
    d.legal = 1'b1;
    // Rows 0 to 3 of the group are other instructions, not compares
    d.compare_branch_unequal = (op[7:4] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_GRP) && (op[3:2] != 2'h0);
    if (op == `LCAO_OP_ANL_C_BIT) begin
      d.len = `LCAO_LEN_2;
      d.ncyc = `LCAO_CYC_2;
      d.rd = 1'b1;
      d.bitop = 1'b1;
    end else if (op == `LCAO_OP_ANL_DIR_IMM) begin
      d.len = `LCAO_LEN_3;
      d.ncyc = `LCAO_CYC_2;
      d.rd = 1'b1;
    end else if (op == `LCAO_OP_ANL_DIR_A || op == `LCAO_OP_DEC_DIR) begin
      d.len = `LCAO_LEN_2;
      d.rd = 1'b1;
    end else if (d.compare_branch_unequal) begin
      d.len = `LCAO_LEN_3;
      d.ncyc = `LCAO_CYC_2;
      d.rd = (op == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_A_DIR) || (op[7:1] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_IND);
    end else if (op == `LCAO_OP_CLR_BIT) begin
      d.len = `LCAO_LEN_2;
      d.bitop = 1'b1;
    end else if (op != `LCAO_OP_BCD) begin
      d.legal = 1'b0;
    end
    return d;
  endfunction : lcao_decode

  assign dec = lcao_decode(r.op);
  assign cycle_en = (r.div == `LCAO_DIV_LAST);
  assign last = (r.state == lcao_pkg::ST_WAIT) && (r.cnt == dec.ncyc - 2'h1);
  assign issue_ready = cycle_en && (r.state == lcao_pkg::ST_IDLE || last);
  assign take = issue_ready && issue_valid;

  always_comb begin
    first = r.rdata;
    second = r.b2;
    if (r.op == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_A_IMM || r.op == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_A_DIR) begin
      first = r.acc;
    end
    if (r.op[7:3] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_REG) begin
      first = r.oper;
    end
    if (r.op == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_A_DIR) begin
      second = r.rdata;
    end
    if (r.op == `LCAO_OP_ANL_DIR_A) begin
      second = r.acc;
    end
    if (r.op == `LCAO_OP_ANL_DIR_IMM) begin
      second = r.b3;
    end
  end

  lcao_alu u_alu (
    .op(r.op),
    .first(first),
    .second(second),
    .acc(r.acc),
    .cin(r.cin),
    .hcin(r.hcin),
    .res(alu_res),
    .c(alu_c),
    .eq(alu_eq)
  );

  always_comb begin
    next_r = r;
    next_r.div = cycle_en ? 4'h0 : r.div + 4'h1;
    next_r.done = 1'b0;
    next_r.wr_en = 1'b0;
    next_r.carry_we = 1'b0;
    next_r.acc_we = 1'b0;
    next_r.taken = 1'b0;
    next_r.illegal = 1'b0;
    unique case (r.state)
      lcao_pkg::ST_IDLE: begin
      end
      lcao_pkg::ST_ADDR: begin
        // Waits out the commit cycle so forwarded writes have landed
        if (!r.done) begin
          next_r.acc = acc_in;
          next_r.cin = carry_in;
          next_r.hcin = half_carry_flag_in;
          next_r.oper = bank_reg_data;
          next_r.bitsel = dec.bitop;
          next_r.addr = (r.op[7:1] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_IND) ? bank_reg_data
                                                         : r.b2;
          next_r.state = dec.rd ? lcao_pkg::ST_READ : lcao_pkg::ST_WAIT;
        end
      end
      lcao_pkg::ST_READ: begin
        next_r.state = lcao_pkg::ST_CAPT;
      end
      lcao_pkg::ST_CAPT: begin
        next_r.rdata = mem_rdata;
        next_r.state = lcao_pkg::ST_WAIT;
      end
      lcao_pkg::ST_WAIT: begin
        if (cycle_en) begin
          next_r.cnt = r.cnt + 2'h1;
        end
        if (last && cycle_en) begin
          next_r.state = lcao_pkg::ST_IDLE;
          next_r.done = 1'b1;
          next_r.illegal = !dec.legal;
          next_r.wr_en = r.op == `LCAO_OP_ANL_DIR_IMM
                      || r.op == `LCAO_OP_ANL_DIR_A
                      || r.op == `LCAO_OP_DEC_DIR
                      || r.op == `LCAO_OP_CLR_BIT;
          next_r.wr_data = (r.op == `LCAO_OP_CLR_BIT) ? 8'h00 : alu_res;
          next_r.carry_we = dec.compare_branch_unequal || r.op == `LCAO_OP_ANL_C_BIT
                         || r.op == `LCAO_OP_BCD;
          next_r.carry_val = alu_c;
          next_r.acc_we = (r.op == `LCAO_OP_BCD);
          next_r.acc_val = alu_res;
          next_r.taken = dec.compare_branch_unequal && !alu_eq;
          next_r.pc_out = r.pc + {14'h0000, dec.len}
                        + ((dec.compare_branch_unequal && !alu_eq) ? {{8{r.b3[7]}}, r.b3}
                                                 : 16'h0000);
        end
      end
    endcase
    if (take) begin
      next_r.state = lcao_pkg::ST_ADDR;
      next_r.op = issue_opcode;
      next_r.b2 = issue_byte2;
      next_r.b3 = issue_byte3;
      next_r.pc = issue_pc;
      next_r.cnt = 2'h0;
      next_r.regsel = (issue_opcode[7:3] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_REG)
                    ? issue_opcode[2:0] : {2'h0, issue_opcode[0]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.state <= lcao_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign bank_reg_sel = r.regsel;
  assign mem_rd = (r.state == lcao_pkg::ST_READ);
  assign mem_addr = r.addr;
  assign mem_bit = r.bitsel;
  assign mem_wr = r.wr_en;
  assign mem_wdata = r.wr_data;
  assign carry_we = r.carry_we;
  assign carry_out = r.carry_val;
  assign acc_we = r.acc_we;
  assign acc_out = r.acc_val;
  assign done = r.done;
  assign illegal = r.illegal;
  assign branch_taken = r.taken;
  assign next_pc = r.pc_out;

  localparam int MC1 = `LCAO_CLKS_INT + 1;
  localparam int MC2 = 2 * `LCAO_CLKS_INT + 1;
  // Done clear for eight clocks from T+2, then due at T+MC2
  localparam int MC2_REST = MC2 - 9;

  lcao_pkg::lcao_dec_t issue_dec;
  assign issue_dec = lcao_decode(issue_opcode);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence take_one_s;
    take && issue_dec.ncyc == `LCAO_CYC_1;
  endsequence
  sequence take_two_s;
    take && issue_dec.ncyc == `LCAO_CYC_2;
  endsequence
  // A take on the commit clock replaces r.op, so only idle commits count
  sequence fin_s(logic [7:0] code);
    done && r.state == lcao_pkg::ST_IDLE && r.op == code;
  endsequence
  sequence fin_cmp_s;
    done && r.state == lcao_pkg::ST_IDLE && dec.compare_branch_unequal;
  endsequence

  cyc_one_a: assert property (take_one_s |-> ##MC1 done)
    else $error("one-cycle op did not finish on time");
  cyc_two_a: assert property (
    take_two_s |-> ##2 (!done)[*8] ##MC2_REST done)
    else $error("two-cycle op finished at wrong time");
  anl_carry_a: assert property (
    fin_s(`LCAO_OP_ANL_C_BIT) |-> carry_we && !mem_wr
      && carry_out == (r.cin & r.rdata[0]))
    else $error("carry AND result wrong");
  anl_imm_a: assert property (
    fin_s(`LCAO_OP_ANL_DIR_IMM) |-> mem_wr && !carry_we
      && mem_wdata == (r.rdata & r.b3) && mem_addr == r.b2)
    else $error("AND immediate to memory wrong");
  anl_acc_a: assert property (
    fin_s(`LCAO_OP_ANL_DIR_A) |-> mem_wr && !carry_we
      && mem_wdata == (r.rdata & r.acc))
    else $error("AND accumulator to memory wrong");
  cmp_branch_a: assert property (
    fin_cmp_s |-> branch_taken == (first != second)
      && next_pc == r.pc + 16'h0003
                    + (branch_taken ? {{8{r.b3[7]}}, r.b3} : 16'h0000))
    else $error("compare branch target wrong");
  cmp_carry_a: assert property (
    fin_cmp_s |-> carry_we && carry_out == (first < second)
      && !mem_wr && !acc_we)
    else $error("compare carry wrong");
  cmp_reg_a: assert property (
    take && issue_opcode[7:3] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_REG
      |=> bank_reg_sel == $past(issue_opcode[2:0]))
    else $error("register compare used wrong register");
  clr_bit_a: assert property (
    fin_s(`LCAO_OP_CLR_BIT) |-> mem_wr && mem_bit && mem_wdata == 8'h00
      && !carry_we)
    else $error("bit clear wrong");
  bcd_low_a: assert property (
    fin_s(`LCAO_OP_BCD) |-> acc_out[3:0] == 4'(r.acc[3:0]
      + ((r.acc[3:0] > `LCAO_BCD_MAX || r.hcin)
         ? 4'(`LCAO_BCD_LO_FIX) : 4'h0)))
    else $error("BCD low digit wrong");
  bcd_carry_a: assert property (
    fin_s(`LCAO_OP_BCD) |-> acc_we && carry_we && (!r.cin || carry_out)
      && (r.acc[7:4] <= `LCAO_BCD_MAX || carry_out))
    else $error("BCD correction wrong");
  dec_mem_a: assert property (
    fin_s(`LCAO_OP_DEC_DIR) |-> mem_wr && !carry_we
      && mem_wdata == r.rdata - 8'h01 && next_pc == r.pc + 16'h0002)
    else $error("memory decrement wrong");
endmodule : lcao_core

// ==== hw/lcao_consts.svh ====
// Opcode, length, cycle and timing constants for the logic/compare unit
`ifndef LCAO_CONSTS_SVH
`define LCAO_CONSTS_SVH
`define LCAO_OP_ANL_C_BIT 8'h82
`define LCAO_OP_ANL_DIR_IMM 8'h53
`define LCAO_OP_ANL_DIR_A 8'h52
`define LCAO_OP_COMPARE_BRANCH_UNEQUAL_IND 7'h5B
`define LCAO_OP_COMPARE_BRANCH_UNEQUAL_A_IMM 8'hB4
`define LCAO_OP_COMPARE_BRANCH_UNEQUAL_A_DIR 8'hB5
`define LCAO_OP_COMPARE_BRANCH_UNEQUAL_REG 5'h17
`define LCAO_OP_COMPARE_BRANCH_UNEQUAL_GRP 4'hB
`define LCAO_OP_CLR_BIT 8'hC2
`define LCAO_OP_BCD 8'hD4
`define LCAO_OP_DEC_DIR 8'h15
`define LCAO_LEN_1 2'h1
`define LCAO_LEN_2 2'h2
`define LCAO_LEN_3 2'h3
`define LCAO_CYC_1 2'h1
`define LCAO_CYC_2 2'h2
`define LCAO_BCD_MAX 4'h9
`define LCAO_BCD_LO_FIX 9'h006
`define LCAO_BCD_HI_FIX 9'h060
`define LCAO_CLKS_INT 12
`define LCAO_DIV_LAST 4'(`LCAO_CLKS_INT - 1)
`endif

// ==== hw/lcao_pkg.sv ====
// Types shared by the logic/compare execution unit
package lcao_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_READ = 5'h04,
    ST_CAPT = 5'h08,
    ST_WAIT = 5'h10
  } lcao_state_t;

  typedef struct packed {
    logic legal;
    logic [1:0] len;
    logic [1:0] ncyc;
    logic rd;
    logic bitop;
    logic compare_branch_unequal;
  } lcao_dec_t;

  typedef struct packed {
    lcao_state_t state;
    logic [3:0] div;
    logic [1:0] cnt;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [15:0] pc;
    logic cin;
    logic hcin;
    logic [7:0] acc;
    logic [7:0] oper;
    logic [7:0] rdata;
    logic [7:0] addr;
    logic bitsel;
    logic [2:0] regsel;
    logic done;
    logic illegal;
    logic wr_en;
    logic [7:0] wr_data;
    logic carry_we;
    logic carry_val;
    logic acc_we;
    logic [7:0] acc_val;
    logic taken;
    logic [15:0] pc_out;
  } lcao_regs_t;
endpackage : lcao_pkg

// ==== hw/lcao_alu.sv ====
// Combinational datapath: AND, decrement, compare and BCD correction
`timescale 1ns/1ns
`include "lcao_consts.svh"
module lcao_alu (
  input wire logic [7:0] op,
  input wire logic [7:0] first,
  input wire logic [7:0] second,
  input wire logic [7:0] acc,
  input wire logic cin,
  input wire logic hcin,
  output logic [7:0] res,
  output logic c,
  output logic eq
);
  always_comb begin
    logic [8:0] t;
    t = {1'b0, acc};
    res = 8'h00;
    c = cin;
    eq = (first == second);
    if (op == `LCAO_OP_ANL_C_BIT) begin
      c = cin & first[0];
    end else if (op == `LCAO_OP_ANL_DIR_IMM || op == `LCAO_OP_ANL_DIR_A) begin
      res = first & second;
    end else if (op == `LCAO_OP_DEC_DIR) begin
      res = first - 8'h01;
    end else if (op[7:4] == `LCAO_OP_COMPARE_BRANCH_UNEQUAL_GRP && op[3:2] != 2'h0) begin
      c = (first < second);
    end else if (op == `LCAO_OP_BCD) begin
      if (acc[3:0] > `LCAO_BCD_MAX || hcin) begin
        t = t + `LCAO_BCD_LO_FIX;
      end
      // High digit sees the carry out of the low correction
      if (t[8:4] > {1'b0, `LCAO_BCD_MAX} || cin) begin
        t = t + `LCAO_BCD_HI_FIX;
        c = 1'b1;
      end
      res = t[7:0];
    end
  end
endmodule : lcao_alu

// ==== testbench/tb_logic_compare_adjust_ops.sv ====
// Self-checking bench for the logic, compare and adjust execution unit
`timescale 1ns/1ns
module tb_logic_compare_adjust_ops;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic issue_valid = 1'b0;
  logic carry_in = 1'b0;
  logic hc_in = 1'b0;
  logic [7:0] op = 8'h00, b2 = 8'h00, b3 = 8'h00, acc_in = 8'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic issue_ready, mem_rd, mem_bit, mem_wr, carry_we, carry_out, acc_we;
  logic done, illegal, branch_taken;
  logic [7:0] mem_addr, mem_wdata, acc_out, bank_reg_data;
  logic [2:0] bank_reg_sel;
  logic [15:0] next_pc;
  logic [7:0] regs [8];
  int miscompares = 0;
  int checks_done = 0;
  int lat;
  int rds;
  localparam logic [15:0] PC = 16'h0100;

  // Bank register file read port, combinational as the core expects
  assign bank_reg_data = regs[bank_reg_sel];

  always #50 clock = ~clock;

  lcao_core i_dut (
    .clock(clock), .arst_n(arst_n), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_opcode(op), .issue_byte2(b2),
    .issue_byte3(b3), .issue_pc(PC), .acc_in(acc_in),
    .carry_in(carry_in), .half_carry_flag_in(hc_in),
    .bank_reg_sel(bank_reg_sel), .bank_reg_data(bank_reg_data),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_bit(mem_bit),
    .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .carry_we(carry_we), .carry_out(carry_out), .acc_we(acc_we),
    .acc_out(acc_out), .done(done), .illegal(illegal),
    .branch_taken(branch_taken), .next_pc(next_pc)
  );

  task automatic complete_run;
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Inputs held for the whole op; returns at the done cycle
  task automatic run(input logic [7:0] o, x2, x3, a, m, input logic c, h,
                     input logic [2:0] ri, input logic [7:0] rv);
    int n;
    @(posedge clock);
    op <= o;
    b2 <= x2;
    b3 <= x3;
    acc_in <= a;
    mem_rdata <= m;
    carry_in <= c;
    hc_in <= h;
    regs[ri] <= rv;
    issue_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (issue_ready !== 1'b1 && n < 40);
    @(posedge clock);
    issue_valid <= 1'b0;
    lat = 0;
    rds = 0;
    do begin
      @(negedge clock);
      lat++;
      if (mem_rd === 1'b1) rds++;
    end while (done !== 1'b1 && lat < 40);
    if (n >= 40 || lat >= 40) begin
      miscompares++;
      complete_run();
    end
  endtask : run

  // Latency, side-effect strobes and following address
  task automatic verify(input int cyc, len, input logic [4:0] fl);
    logic rd_exp;
    // Only the forms that operate on a memory byte read it, once
    rd_exp = op inside {8'h82, 8'h53, 8'h52, 8'h15, 8'hB5, 8'hB6, 8'hB7};
    check(16'(rds), 16'(rd_exp));
    check(16'(lat), 16'(12 * cyc + 1));
    check({11'h000, illegal, branch_taken, mem_wr, carry_we, acc_we},
          {11'h000, fl});
    check(next_pc, PC + 16'(len) + (fl[3] ? {{8{b3[7]}}, b3} : 16'h0000));
  endtask : verify

  task automatic s_and_carry;
    for (int i = 0; i < 4; i++) begin
      run(8'h82, 8'hE5, 8'h00, 8'h00, {7'h55, i[0]}, i[1], 1'b0, 3'h7, 8'hE7);
      verify(2, 2, 5'h02);
      check({mem_addr, 7'h00, mem_bit}, 16'hE501);
      check(16'(carry_out), 16'(i[0] & i[1]));
    end
  endtask : s_and_carry

  task automatic s_and_mem;
    run(8'h53, 8'h47, 8'h3C, 8'hFF, 8'hF0, 1'b1, 1'b1, 3'h7, 8'hE7);
    verify(2, 3, 5'h04);
    check({mem_addr, mem_wdata}, 16'h4730);
    run(8'h52, 8'h88, 8'h00, 8'h5A, 8'hAF, 1'b1, 1'b1, 3'h7, 8'hE7);
    verify(1, 2, 5'h04);
    check({mem_addr, mem_wdata}, 16'h880A);
  endtask : s_and_mem

  task automatic s_clear_dec;
    run(8'hC2, 8'hE5, 8'h00, 8'h00, 8'hFF, 1'b1, 1'b1, 3'h7, 8'hE7);
    verify(1, 2, 5'h04);
    check({mem_addr, 6'h00, mem_bit, mem_wdata[0]}, 16'hE502);
    // Wrap through zero and the sign boundary
    run(8'h15, 8'h5A, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 3'h7, 8'hE7);
    verify(1, 2, 5'h04);
    check({mem_addr, mem_wdata}, 16'h5AFF);
    run(8'h15, 8'h21, 8'h00, 8'h00, 8'h80, 1'b0, 1'b0, 3'h7, 8'hE7);
    verify(1, 2, 5'h04);
    check({mem_addr, mem_wdata}, 16'h217F);
    run(8'hA5, 8'h21, 8'h00, 8'h00, 8'h80, 1'b0, 1'b0, 3'h7, 8'hE7);
    verify(1, 1, 5'h10);
    // Low rows of the compare group are not compares
    run(8'hB3, 8'h21, 8'h00, 8'h00, 8'h80, 1'b0, 1'b0, 3'h7, 8'hE7);
    verify(1, 1, 5'h10);
  endtask : s_clear_dec

  // Every compare form, equal, below and above, both offset extremes
  task automatic s_compare;
    logic [7:0] f, s, o, x2, a, m, rv;
    logic [2:0] ri;
    for (int i = 0; i < 36; i++) begin
      o = 8'hB4 + 8'(i / 3);
      f = (i % 3 == 0) ? 8'h5A : ((i % 3 == 1) ? 8'h10 : 8'h20);
      s = (i % 3 == 0) ? 8'h5A : ((i % 3 == 1) ? 8'h20 : 8'h10);
      x2 = (o == 8'hB5) ? 8'h33 : s;
      a = (o < 8'hB6) ? f : 8'hC3;
      m = (o == 8'hB5) ? s : ((o < 8'hB8) ? f : 8'hC3);
      ri = (o < 8'hB8) ? {2'h0, o[0]} : o[2:0];
      rv = (o < 8'hB8) ? {7'h20, o[0]} : f;
      run(o, x2, i[0] ? 8'h80 : 8'h7F, a, m, ~(f < s), 1'b0, ri, rv);
      verify(2, 3, {1'b0, f != s, 3'h2});
      check(16'(carry_out), 16'(f < s));
      if (o inside {8'hB5, 8'hB6, 8'hB7}) begin
        check(16'(mem_addr), 16'(o == 8'hB5 ? 8'h33 : rv));
      end
    end
  endtask : s_compare

  task automatic s_bcd;
    logic [7:0] tab [6] = '{8'h9C, 8'hB5, 8'h29, 8'h0F, 8'h99, 8'h9A};
    logic [8:0] r;
    logic hf;
    for (int i = 0; i < 24; i++) begin
      r = {1'b0, tab[i / 4]};
      if (r[3:0] > 4'h9 || i[1]) r = r + 9'h006;
      hf = r[8:4] > 5'h09 || i[0];
      if (hf) r = r + 9'h060;
      run(8'hD4, 8'h00, 8'h00, tab[i / 4], 8'h00, i[0], i[1], 3'h7, 8'hE7);
      check(16'(lat), 16'h000D);
      check({acc_out, 4'h0, acc_we, mem_wr, carry_we, carry_out},
            {r[7:0], 4'h0, 1'b1, 1'b0, 1'b1, hf});
    end
  endtask : s_bcd

  initial begin
    for (int i = 0; i < 8; i++) regs[i] = 8'hE0 + 8'(i);
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    s_and_carry();
    s_and_mem();
    s_clear_dec();
    s_compare();
    s_bcd();
    complete_run();
  end
endmodule : tb_logic_compare_adjust_ops
